// ---- core/lptu_pkg.sv ----
// Package of the latch, key port and timer unit: constants and carrier types.
// Assumes one clock domain (mclk) and single-cycle command strobes from the core.
package lptu_pkg;

  // Latch positions of the digit latch bank
  localparam int LATCH_COUNT = 14;
  localparam logic [3:0] LATCH_CLOCK = 4'h0;      // Reserved: clock steering
  localparam logic [3:0] LATCH_STROBE_FIRST = 4'h1;
  localparam logic [3:0] LATCH_STROBE_LAST = 4'h6;
  localparam logic [3:0] LATCH_MEMSUP = 4'h7;     // Reserved: memory supply
  localparam int POS_PORT_DIR = 8;
  localparam int POS_BATTERY = 9;
  localparam int POS_SEL_A = 10;
  localparam int POS_SEL_B = 11;
  localparam int POS_TIMER_RATE = 12;
  localparam int POS_CUR_SRC = 13;
  localparam logic [3:0] LATCH_LAST = 4'hd;

  // Values after reset
  localparam logic [13:0] LATCH_RESET = 14'h0000;
  localparam logic [3:0] PORT_LATCH_RESET = 4'h0;
  localparam logic [7:0] TIMER_RESET = 8'h00;
  localparam logic [8:0] COUNT_RESET = 9'h000;

  // Hardware timer runs at 16 Hz; one second is sixteen ticks
  localparam logic [3:0] TICKS_PER_SECOND_LAST = 4'hf;

  // Expiry flag numbers in flag group one
  localparam logic [3:0] FLAG_LONG = 4'ha;
  localparam logic [3:0] FLAG_SHORT = 4'hb;

  // Latch set or clear request
  typedef struct packed {
    logic set;        // latch_set_cmd
    logic clear;      // latch_clear_cmd
    logic [3:0] addr; // Latch position
  } lptu_latch_cmd_type;

  // Status update from the arithmetic path
  typedef struct packed {
    logic update;     // Instruction affects status
    logic arith;      // Arithmetic instruction: sign decides
    logic result_neg; // Result sign
    logic result_zero;
    logic error;      // Non-arithmetic error indication
  } lptu_status_in_type;

  // Timer and flag commands
  typedef struct packed {
    logic long_load;   // long_timer_load_cmd
    logic short_load;  // short_timer_load_cmd
    logic long_halt;   // long_timer_halt_cmd
    logic short_halt;  // short_timer_halt_cmd
    logic update;      // timer_update_cmd
    logic flag_clear;  // flag_clear_cmd
    logic [3:0] flag;  // Flag number for flag_clear_cmd
    logic [7:0] value; // Load value
  } lptu_timer_cmd_type;

endpackage

// ---- core/lptu_core.sv ----
// Latch, status, key port and timer unit of a 4-bit sensor processor.
// Assumes command strobes last one mclk cycle and come from mclk logic; key pins
// and the 16 Hz tick come from outside and are synchronised here.
// Summary of operation
// - Six settable latches drive strobe outputs one-six
// - Positions zero and seven ignore user latch commands
// - Direction latch: zero input, one output
// - Battery latch overrides; else two bits pick input
// - Measure command writes the three selection latches
// - Rate latch picks 1 Hz or 16 Hz view
// - Current source on only with latch and supply
// - Set drives one, clear zero, others unchanged
// - Reset clears latches; low power keeps them
// - Three status bits hold until next update
// - Zero bit marks zero result or equality
// - Positive bit: positive sign or no error
// - Negative bit: negative sign or error
// - Output direction drives latch, bit eight MSB
// - Read gives pins or latch by direction
// - Bits one two four wake on rise
// - Bit eight wakes on change, armed at entry
// - Eight-bit hardware timer counts 16 Hz ticks
// - Timers count down, expiry sets flags, wakes in done mode
// - Timer logic only sets flags; flags force done-mode exit
// - Expiry reloads by adding buffer to count
// - Load starts timer; halted timer ignores updates
// - Load and halt clear their expiry flag
`timescale 1ns/1ps

module lptu_core
  import lptu_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire lptu_latch_cmd_type latch_cmd,
  input wire logic measure_cmd,
  input wire logic [2:0] measure_operand,
  input wire lptu_status_in_type status_in,
  input wire logic [3:0] key_in,
  input wire logic port_constant_write_cmd,
  input wire logic accumulator_port_write_cmd,
  input wire logic [3:0] port_write_data,
  input wire logic port_read_cmd,
  input wire logic port_read_update_cmd,
  input wire lptu_timer_cmd_type timer_cmd,
  input wire logic tick_16hz,
  input wire logic converter_supply,
  input wire logic clock_control_req,
  input wire logic memory_supply_req,
  input wire logic low_power_enter,
  input wire logic low_power_done,
  input wire logic active_restore,
  output logic [6:1] strobe_outputs,
  output logic clock_control_output,
  output logic memory_supply_output,
  output logic port_direction_latch,
  output logic battery_select_latch,
  output logic [1:0] input_select,
  output logic timer_rate_latch,
  output logic current_source_on,
  output logic status_pos,
  output logic sign_minus_flag,
  output logic status_zero,
  output logic [3:0] key_out,
  output logic [3:0] key_oe,
  output logic [3:0] port_read_data,
  output logic port_read_valid,
  output logic [7:0] timer_view,
  output logic long_timer_expired,
  output logic short_timer_expired,
  output logic wake_request
);

  // Whole state of the unit in one record
  typedef struct packed {
    logic [13:0] latch;     // Digit latch bank, position 0..13
    logic clk_ctl;          // Reserved position zero
    logic mem_sup;          // Reserved position seven
    logic pos;              // Status bits
    logic neg;
    logic zero;
    logic [3:0] port_latch; // Key port output latch
    logic [3:0] key_s1;     // Key synchroniser, first stage
    logic [3:0] key_s2;     // Key synchroniser, second stage
    logic [3:0] key_prev;   // Previous synchronised level
    logic tick_s1;          // Tick synchroniser
    logic tick_s2;
    logic tick_prev;
    logic tick_seen;        // A tick was counted last cycle
    logic [7:0] hw_timer;   // Free-running 16 Hz count
    logic [8:0] long_cnt;   // Software timers, one guard bit
    logic [8:0] short_cnt;
    logic [7:0] long_rel;   // Reload buffers
    logic [7:0] short_rel;
    logic long_run;
    logic short_run;
    logic [7:0] long_pend;  // Seconds elapsed since last update
    logic [7:0] short_pend; // Ticks elapsed since last update
    logic long_exp;
    logic short_exp;
    logic low_power;        // In done or off mode
    logic done_mode;        // Done mode (timers may wake)
    logic k8_armed;         // Bit eight level at mode entry
    logic pre_ok;           // Bits one, two, four were all low
    logic wake;
    logic [3:0] rd_data;
    logic rd_valid;
    logic cur_src;
    logic [7:0] tview;
  } lptu_state_type;

  lptu_state_type st_reg;
  lptu_state_type st_next;

  // Subtract elapsed units; at or below zero add the reload value back
  // Limitation: two underflows within one update interval lose a whole period
  function automatic logic [9:0] timer_step(input logic [8:0] cnt, input logic [7:0] pend,
                                            input logic [7:0] rel);
    logic [9:0] diff;
    logic [9:0] res;
    diff = {1'b0, cnt} - {2'b00, pend};
    res = {1'b0, diff[8:0]};
    if (diff[9] || diff == 10'h000) begin
      res = {1'b1, 9'(diff[8:0] + {1'b0, rel})};
    end
    return res;
  endfunction

  // Next-state logic
  always_comb begin
    logic tick;
    logic upd;
    logic second;
    logic [9:0] lstep;
    logic [9:0] sstep;
    logic key_wake;
    logic timer_wake;
    tick = 1'b0;
    upd = 1'b0;
    second = 1'b0;
    lstep = 10'h000;
    sstep = 10'h000;
    key_wake = 1'b0;
    timer_wake = 1'b0;
    st_next = st_reg;

    // Synchronisers; only the second stage is read by logic
    st_next.key_s1 = key_in;
    st_next.key_s2 = st_reg.key_s1;
    st_next.key_prev = st_reg.key_s2;
    st_next.tick_s1 = tick_16hz;
    st_next.tick_s2 = st_reg.tick_s1;
    st_next.tick_prev = st_reg.tick_s2;
    tick = st_reg.tick_s2 & ~st_reg.tick_prev;
    st_next.tick_seen = tick;

    // Reserved positions follow the control software only
    st_next.clk_ctl = clock_control_req;
    st_next.mem_sup = memory_supply_req;

    // User latch commands; positions zero, seven and above thirteen are ignored
    if (latch_cmd.addr != LATCH_CLOCK && latch_cmd.addr != LATCH_MEMSUP &&
        latch_cmd.addr <= LATCH_LAST) begin
      if (latch_cmd.set) begin
        st_next.latch[latch_cmd.addr] = 1'b1;
      end else if (latch_cmd.clear) begin
        st_next.latch[latch_cmd.addr] = 1'b0;
      end
    end

    // Measure steers the selection latches; it wins over a latch command
    if (measure_cmd) begin
      st_next.latch[POS_BATTERY] = measure_operand[2];
      st_next.latch[POS_SEL_A] = measure_operand[0];
      st_next.latch[POS_SEL_B] = measure_operand[1];
    end

    // Current source needs both the latch and the converter supply
    st_next.cur_src = st_reg.latch[POS_CUR_SRC] & converter_supply;

    // Status bits change only on a status-affecting instruction
    if (status_in.update) begin
      st_next.zero = status_in.result_zero;
      if (status_in.arith) begin
        st_next.pos = ~status_in.result_neg;
        st_next.neg = status_in.result_neg;
      end else begin
        st_next.pos = ~status_in.error;
        st_next.neg = status_in.error;
      end
    end

    // Key port latch write; direction latch is left alone
    if (port_constant_write_cmd || accumulator_port_write_cmd) begin
      st_next.port_latch = port_write_data;
    end

    // Port read: pins in input direction, latch in output direction
    st_next.rd_valid = port_read_cmd | port_read_update_cmd;
    if (port_read_cmd || port_read_update_cmd) begin
      st_next.rd_data = st_reg.latch[POS_PORT_DIR] ? st_reg.port_latch : st_reg.key_s2;
    end

    // Hardware timer and elapsed-time accumulation
    if (tick) begin
      st_next.hw_timer = st_reg.hw_timer + 8'h01;
      second = st_reg.hw_timer[3:0] == TICKS_PER_SECOND_LAST;
      // Saturate so a very late update still expires the timer
      if (st_reg.short_pend != 8'hff) begin
        st_next.short_pend = st_reg.short_pend + 8'h01;
      end
      if (second && st_reg.long_pend != 8'hff) begin
        st_next.long_pend = st_reg.long_pend + 8'h01;
      end
    end
    // Rate latch chooses the 16 Hz count or the whole seconds
    st_next.tview = st_reg.latch[POS_TIMER_RATE] ? st_reg.hw_timer :
                    {4'h0, st_reg.hw_timer[7:4]};

    // Timers update on command, or by themselves each tick in done mode
    upd = timer_cmd.update | port_read_update_cmd |
          (st_reg.low_power & st_reg.done_mode & st_reg.tick_seen);
    lstep = timer_step(st_reg.long_cnt, st_reg.long_pend, st_reg.long_rel);
    sstep = timer_step(st_reg.short_cnt, st_reg.short_pend, st_reg.short_rel);
    if (upd && st_reg.long_run) begin
      st_next.long_cnt = lstep[8:0];
      st_next.long_pend = {7'h00, tick & second};
      if (lstep[9]) begin
        st_next.long_exp = 1'b1;
      end
    end
    if (upd && st_reg.short_run) begin
      st_next.short_cnt = sstep[8:0];
      st_next.short_pend = {7'h00, tick};
      if (sstep[9]) begin
        st_next.short_exp = 1'b1;
      end
    end

    // Software flag clear; a same-cycle expiry wins
    if (timer_cmd.flag_clear) begin
      if (timer_cmd.flag == FLAG_LONG && !(upd && st_reg.long_run && lstep[9])) begin
        st_next.long_exp = 1'b0;
      end
      if (timer_cmd.flag == FLAG_SHORT && !(upd && st_reg.short_run && sstep[9])) begin
        st_next.short_exp = 1'b0;
      end
    end

    // Load starts a timer, halt stops it; both clear its flag
    if (timer_cmd.long_load) begin
      st_next.long_rel = timer_cmd.value;
      st_next.long_cnt = {1'b0, timer_cmd.value};
      st_next.long_pend = 8'h00;
      st_next.long_run = 1'b1;
      st_next.long_exp = 1'b0;
    end else if (timer_cmd.long_halt) begin
      st_next.long_run = 1'b0;
      st_next.long_exp = 1'b0;
    end
    if (timer_cmd.short_load) begin
      st_next.short_rel = timer_cmd.value;
      st_next.short_cnt = {1'b0, timer_cmd.value};
      st_next.short_pend = 8'h00;
      st_next.short_run = 1'b1;
      st_next.short_exp = 1'b0;
    end else if (timer_cmd.short_halt) begin
      st_next.short_run = 1'b0;
      st_next.short_exp = 1'b0;
    end

    // Pattern before wake-up: bits one, two and four all low
    st_next.pre_ok = ~|st_reg.key_s2[2:0];

    // Low-power entry arms the bit-eight detector
    if (low_power_enter && !st_reg.low_power) begin
      st_next.low_power = 1'b1;
      st_next.done_mode = low_power_done;
      st_next.k8_armed = st_reg.key_s2[3];
    end

    // Wake sources while in low power
    key_wake = st_reg.low_power & st_reg.pre_ok &
               ((|(st_reg.key_s2[2:0] & ~st_reg.key_prev[2:0])) |
                ((st_reg.key_s2[3] != st_reg.k8_armed) & ~|st_reg.key_s2[2:0]));
    // A pending flag makes done mode exit at once
    timer_wake = st_reg.low_power & st_reg.done_mode &
                 (st_reg.long_exp | st_reg.short_exp);

    // Held wake level until active mode is restored; a new wake wins
    if (active_restore) begin
      st_next.wake = 1'b0;
      st_next.low_power = 1'b0;
      st_next.done_mode = 1'b0;
    end
    // A flag level is no new cause once restore acknowledges it; letting it win
    // would hold the request high through the whole active period
    if (key_wake || (timer_wake && !active_restore)) begin
      st_next.wake = 1'b1;
    end
  end

  // State register; latches survive low power, reset clears them all
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
      st_reg.latch <= LATCH_RESET;
      st_reg.port_latch <= PORT_LATCH_RESET;
      st_reg.hw_timer <= TIMER_RESET;
      st_reg.long_cnt <= COUNT_RESET;
      st_reg.short_cnt <= COUNT_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state register
  always_comb begin
    strobe_outputs = st_reg.latch[6:1];
    clock_control_output = st_reg.clk_ctl;
    memory_supply_output = st_reg.mem_sup;
    port_direction_latch = st_reg.latch[POS_PORT_DIR];
    // Battery latch wins; selection bits then do not matter
    battery_select_latch = st_reg.latch[POS_BATTERY];
    input_select = {st_reg.latch[POS_SEL_B], st_reg.latch[POS_SEL_A]};
    timer_rate_latch = st_reg.latch[POS_TIMER_RATE];
    current_source_on = st_reg.cur_src;
    status_pos = st_reg.pos;
    sign_minus_flag = st_reg.neg;
    status_zero = st_reg.zero;
    key_out = st_reg.port_latch;
    // One direction for all four pins; the port has no per-pin direction
    key_oe = {4{st_reg.latch[POS_PORT_DIR]}};
    port_read_data = st_reg.rd_data;
    port_read_valid = st_reg.rd_valid;
    timer_view = st_reg.tview;
    long_timer_expired = st_reg.long_exp;
    short_timer_expired = st_reg.short_exp;
    wake_request = st_reg.wake;
  end

endmodule // lptu_core

// ---- testbench/lptu_keys.sv ----
// Key and switch model on the four-bit key port.
// Assumes key_oe high means the core drives that pin.
`timescale 1ns/1ps
module lptu_keys
  import lptu_pkg::*;
(
  input wire logic [3:0] key_out,
  input wire logic [3:0] key_oe,
  input wire logic [3:0] press,
  output logic [3:0] key_in
);
  // Switches hold their level; a driven pin shows the core's value
  assign key_in = (key_oe & key_out) | (~key_oe & press);
endmodule // lptu_keys

// ---- testbench/lptu_check_assertions.sv ----
// Port checker of lptu_core, bound to every instance.
// Assumes a single mclk domain with asynchronous active high rst.
`timescale 1ns/1ps
module lptu_check
  import lptu_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire lptu_latch_cmd_type latch_cmd,
  input wire lptu_status_in_type status_in,
  input wire lptu_timer_cmd_type timer_cmd,
  input wire logic port_read_cmd,
  input wire logic converter_supply,
  input wire logic active_restore,
  input wire logic [6:1] strobe_outputs,
  input wire logic port_direction_latch,
  input wire logic current_source_on,
  input wire logic status_pos,
  input wire logic sign_minus_flag,
  input wire logic status_zero,
  input wire logic [3:0] key_out,
  input wire logic [3:0] port_read_data,
  input wire logic port_read_valid,
  input wire logic long_timer_expired,
  input wire logic short_timer_expired,
  input wire logic wake_request
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  a_strobe_set: assert property (latch_cmd.set && latch_cmd.addr inside {[1:6]}
    |=> strobe_outputs[$past(latch_cmd.addr[2:0])]) else $error("strobe not set");
  // Reserved positions must leave every strobe alone
  a_reserved_ignored: assert property ((latch_cmd.set || latch_cmd.clear)
    && latch_cmd.addr inside {4'h0, 4'h7} |=> $stable(strobe_outputs)) else $error("reserved");
  a_clear_drops: assert property (latch_cmd.clear && !latch_cmd.set
    && latch_cmd.addr == 4'h8 |=> !port_direction_latch) else $error("clear failed");
  a_status_arith: assert property (status_in.update && status_in.arith
    |=> status_pos == !$past(status_in.result_neg) && sign_minus_flag
    == $past(status_in.result_neg) && status_zero == $past(status_in.result_zero))
    else $error("arith status");
  a_status_hold: assert property (!status_in.update
    |=> $stable({status_pos, sign_minus_flag, status_zero})) else $error("status moved");
  a_source_gate: assert property (current_source_on |-> $past(converter_supply))
    else $error("source on without supply");
  a_read_latch: assert property (port_read_cmd && port_direction_latch
    |=> port_read_valid && port_read_data == $past(key_out)) else $error("read latch");
  a_wake_hold: assert property (wake_request && !active_restore |=> wake_request)
    else $error("wake dropped");
  a_flag_sticky: assert property (long_timer_expired && !timer_cmd.long_load
    && !timer_cmd.long_halt && !timer_cmd.flag_clear |=> long_timer_expired)
    else $error("flag cleared");
  a_load_clears: assert property (timer_cmd.short_load |=> !short_timer_expired)
    else $error("load kept flag");
endmodule // lptu_check
bind lptu_core lptu_check chk (.*);

// ---- testbench/latch_port_timer_unit_test.sv ----
// Self-checking bench of lptu_core with the key model on its port.
// Assumes 100 MHz mclk; inputs change on the falling edge.
`timescale 1ns/1ps
module latch_port_timer_unit_test;
  import lptu_pkg::*;
  logic mclk = 0;
  logic rst = 1;
  lptu_latch_cmd_type latch_cmd = '0;
  lptu_status_in_type status_in = '0;
  lptu_timer_cmd_type timer_cmd = '0;
  logic measure_cmd = 0, port_constant_write_cmd = 0, accumulator_port_write_cmd = 0;
  logic port_read_cmd = 0, port_read_update_cmd = 0, tick_16hz = 0, converter_supply = 0;
  logic clock_control_req = 0, memory_supply_req = 0, low_power_enter = 0;
  logic low_power_done = 0, active_restore = 0;
  logic [2:0] measure_operand = '0;
  logic [3:0] key_in, key_press = '0, port_write_data = '0, key_out, key_oe, port_read_data;
  logic [6:1] strobe_outputs;
  logic [1:0] input_select;
  logic [7:0] timer_view;
  logic clock_control_output, memory_supply_output, port_direction_latch, battery_select_latch;
  logic timer_rate_latch, current_source_on, status_pos, sign_minus_flag, status_zero;
  logic port_read_valid, long_timer_expired, short_timer_expired, wake_request;
  int fails = 0, cmp_count = 0, cyc = 0, tick_total = 0;
  lptu_core uut (.mclk(mclk), .rst(rst), .latch_cmd(latch_cmd), .measure_cmd(measure_cmd),
    .measure_operand(measure_operand), .status_in(status_in), .key_in(key_in),
    .port_constant_write_cmd(port_constant_write_cmd),
    .accumulator_port_write_cmd(accumulator_port_write_cmd),
    .port_write_data(port_write_data), .port_read_cmd(port_read_cmd),
    .port_read_update_cmd(port_read_update_cmd), .timer_cmd(timer_cmd), .tick_16hz(tick_16hz),
    .converter_supply(converter_supply), .clock_control_req(clock_control_req),
    .memory_supply_req(memory_supply_req), .low_power_enter(low_power_enter),
    .low_power_done(low_power_done), .active_restore(active_restore),
    .strobe_outputs(strobe_outputs), .clock_control_output(clock_control_output),
    .memory_supply_output(memory_supply_output), .port_direction_latch(port_direction_latch),
    .battery_select_latch(battery_select_latch), .input_select(input_select),
    .timer_rate_latch(timer_rate_latch), .current_source_on(current_source_on),
    .status_pos(status_pos), .sign_minus_flag(sign_minus_flag), .status_zero(status_zero),
    .key_out(key_out), .key_oe(key_oe), .port_read_data(port_read_data),
    .port_read_valid(port_read_valid), .timer_view(timer_view),
    .long_timer_expired(long_timer_expired), .short_timer_expired(short_timer_expired),
    .wake_request(wake_request));
  lptu_keys keys (.key_out(key_out), .key_oe(key_oe), .press(key_press), .key_in(key_in));
  always #5 mclk = ~mclk;
  // Hang guard: far above the few hundred cycles the tests need
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      conclude;
    end
  end
  task automatic chk(input string nm, input logic [15:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // One latch command, then time for the output to settle
  task automatic lat(input logic s, input logic [3:0] a);
    latch_cmd = '{set: s, clear: !s, addr: a};
    wait_n(1);
    latch_cmd = '0;
    wait_n(2);
  endtask
  task automatic tgo;
    wait_n(1);
    timer_cmd = '0;
    wait_n(2);
  endtask
  task automatic upd;
    timer_cmd.update = 1;
    tgo;
  endtask
  // Ticks are slow square pulses, well clear of the synchroniser
  task automatic tk(input int n);
    repeat (n) begin
      tick_16hz = 1;
      wait_n(4);
      tick_16hz = 0;
      wait_n(4);
      tick_total++;
    end
  endtask
  task automatic rd(input logic [3:0] x);
    port_read_cmd = 1;
    wait_n(1);
    port_read_cmd = 0;
    chk("read_valid", port_read_valid, 1);
    chk("read_data", port_read_data, x);
  endtask
  task automatic t_latch;
    logic [6:1] e;
    e = '0;
    for (int i = 1; i <= 6; i++) begin
      lat(1, i[3:0]);
      e[i] = 1;
      chk("strobe", strobe_outputs, e);
    end
    lat(1, 4'h0);
    lat(0, 4'h7);
    chk("reserved", {memory_supply_output, clock_control_output, strobe_outputs}, e);
    lat(0, 4'h3);
    e[3] = 0;
    chk("strobe", strobe_outputs, e);
    $display("latch test done");
  endtask
  task automatic t_analog;
    for (int op = 0; op < 8; op++) begin
      measure_operand = op[2:0];
      measure_cmd = 1;
      wait_n(1);
      measure_cmd = 0;
      wait_n(2);
      chk("select", {battery_select_latch, input_select}, op[2:0]);
    end
    lat(1, 4'hd);
    chk("source", current_source_on, 0);
    converter_supply = 1;
    wait_n(3);
    chk("source", current_source_on, 1);
    lat(0, 4'hd);
    chk("source", current_source_on, 0);
    $display("analog test done");
  endtask
  task automatic t_status;
    logic [4:0] v [5] = '{5'b11000, 5'b11110, 5'b10001, 5'b10010, 5'b01111};
    logic [2:0] e [5] = '{3'b100, 3'b011, 3'b010, 3'b101, 3'b101};
    for (int i = 0; i < 5; i++) begin
      status_in = v[i];
      wait_n(1);
      status_in = '0;
      wait_n(1);
      chk("status", {status_pos, sign_minus_flag, status_zero}, e[i]);
    end
    $display("status test done");
  endtask
  task automatic t_port;
    key_press = 4'h5;
    port_write_data = 4'ha;
    port_constant_write_cmd = 1;
    wait_n(1);
    port_constant_write_cmd = 0;
    lat(1, 4'h8);
    chk("oe", key_oe, 4'hf);
    chk("dir", port_direction_latch, 1);
    chk("pins", key_in, 4'ha);
    rd(4'ha);
    lat(0, 4'h8);
    wait_n(3);
    chk("oe", key_oe, 4'h0);
    rd(4'h5);
    lat(1, 4'h8);
    chk("kept", key_out, 4'ha);
    port_write_data = 4'h3;
    accumulator_port_write_cmd = 1;
    wait_n(1);
    accumulator_port_write_cmd = 0;
    wait_n(2);
    rd(4'h3);
    lat(0, 4'h8);
    $display("port test done");
  endtask
  task automatic t_timer;
    lat(1, 4'hc);
    chk("rate", timer_rate_latch, 1);
    timer_cmd.long_load = 1;
    timer_cmd.value = 8'h01;
    tgo;
    timer_cmd.short_load = 1;
    timer_cmd.value = 8'h03;
    tgo;
    tk(2);
    upd;
    chk("short", short_timer_expired, 0);
    tk(2);
    port_read_update_cmd = 1;
    wait_n(1);
    port_read_update_cmd = 0;
    wait_n(2);
    chk("short", short_timer_expired, 1);
    timer_cmd.flag_clear = 1;
    timer_cmd.flag = FLAG_SHORT;
    tgo;
    chk("short", short_timer_expired, 0);
    tk(2);
    upd;
    chk("short", short_timer_expired, 1);
    timer_cmd.short_halt = 1;
    tgo;
    chk("short", short_timer_expired, 0);
    tk(4);
    upd;
    chk("short", short_timer_expired, 0);
    chk("long", long_timer_expired, 0);
    tk(10);
    upd;
    chk("long", long_timer_expired, 1);
    chk("view", timer_view, tick_total);
    timer_cmd.long_halt = 1;
    tgo;
    chk("long", long_timer_expired, 0);
    lat(0, 4'hc);
    chk("view", timer_view, tick_total / 16);
    $display("timer test done");
  endtask
  task automatic enter_rise(input logic [3:0] p);
    key_press = 4'h0;
    wait_n(4);
    low_power_enter = 1;
    wait_n(1);
    low_power_enter = 0;
    wait_n(3);
    chk("wake", wake_request, 0);
    key_press = p;
    wait_n(6);
    chk("wake", wake_request, 1);
    key_press = 4'h0;
    wait_n(6);
    chk("wake", wake_request, 1);
    active_restore = 1;
    wait_n(1);
    active_restore = 0;
    wait_n(2);
    chk("wake", wake_request, 0);
  endtask
  task automatic t_wake;
    enter_rise(4'h2);
    enter_rise(4'h8);
    $display("wake test done");
  endtask
  // Done mode: ticks update a running timer by themselves, expiry wakes, a set flag exits
  task automatic t_done;
    clock_control_req = 1;
    memory_supply_req = 1;
    timer_cmd.short_load = 1;
    timer_cmd.value = 8'h02;
    tgo;
    chk("reserved", {memory_supply_output, clock_control_output}, 2'b11);
    low_power_done = 1;
    low_power_enter = 1;
    wait_n(1);
    low_power_enter = 0;
    wait_n(2);
    chk("wake", wake_request, 0);
    tk(2);
    chk("short", short_timer_expired, 1);
    chk("wake", wake_request, 1);
    active_restore = 1;
    wait_n(1);
    active_restore = 0;
    wait_n(2);
    chk("wake", wake_request, 0);
    low_power_enter = 1;
    wait_n(1);
    low_power_enter = 0;
    wait_n(2);
    chk("wake", wake_request, 1);
    active_restore = 1;
    wait_n(1);
    active_restore = 0;
    wait_n(2);
    chk("wake", wake_request, 0);
    timer_cmd.short_load = 1;
    timer_cmd.value = 8'h05;
    tgo;
    chk("short", short_timer_expired, 0);
    timer_cmd.short_halt = 1;
    tgo;
    low_power_done = 0;
    clock_control_req = 0;
    memory_supply_req = 0;
    $display("done mode test done");
  endtask
  initial begin
    wait_n(8);
    rst = 0;
    wait_n(2);
    t_latch;
    t_analog;
    t_status;
    t_port;
    t_timer;
    t_wake;
    t_done;
    conclude;
  end
endmodule // latch_port_timer_unit_test
